//--- hdl/pmsc_ctrl.sv
// Power mode controller with real-time counter, wake logic and deep sleep memory.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module pmsc_ctrl #(
	parameter int CLK_HZ = 100000000,
	parameter int N_SUP = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic wake_pin,
	input wire logic [N_SUP-1:0] supply_good,
	output logic [N_SUP-1:0] supply_enable,
	output logic [N_SUP-1:0] pulse_frequency_supply_mode,
	output logic node_power_enable,
	output logic clock_mask,
	output logic node_reset,
	output logic system_reset,
	output logic watchdog_enable,
	output logic irq
);

	// ************************************************************
	// Derived constants.
	// ************************************************************
	localparam int SLOW_DIV = CLK_HZ / pmsc_pkg::SLOW_HZ;
	localparam logic [15:0] SLOW_LAST = 16'(SLOW_DIV - 1);
	localparam logic [2:0] TRANS_LAST = 3'(pmsc_pkg::TRANS_CYCLES - 1);

	pmsc_pkg::pmsc_state_type state_ff;
	pmsc_pkg::pmsc_state_type nxt_state;
	logic [2:0] tcnt_ff;
	logic [5:0] sleepcfg_ff;
	logic [3:0] wakecfg_ff;
	logic [63:0] cnt_ff;
	logic [63:0] cmp_ff;
	logic [31:0] incr_ff;
	logic [15:0] slow_ff;
	logic [2:0] stat_ff;
	logic [2:0] mask_ff;
	logic pend_pin_ff;
	logic pend_tmr_ff;
	logic pin_prev_ff;
	logic sys_rst_ff;
	logic [7:0] mem [pmsc_pkg::MEM_BYTES];
	logic wr_en;
	logic rd_en;
	logic sleep_req;
	logic slow_tick;
	logic pin_edge;
	logic tmr_hit;
	logic wake_go;
	logic pg_fail;
	logic in_mem;
	logic [6:0] mem_idx;

	// ************************************************************
	// APB decode; every access completes with no wait state.
	// ************************************************************
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;
	assign in_mem = paddr >= pmsc_pkg::OFF_MEM_BASE;
	assign mem_idx = paddr[6:0];
	assign sleep_req = wr_en && paddr == pmsc_pkg::OFF_CTRL
		&& pwdata[pmsc_pkg::CTRL_SLEEP_BIT] && state_ff == pmsc_pkg::ST_AWAKE;

	// ************************************************************
	// Wake stimuli.
	// ************************************************************
	// The pin wake acts on the edge into the chosen level, so a pin left active cannot re-wake.
	assign pin_edge = wakecfg_ff[pmsc_pkg::WCFG_PIN_EN_BIT]
		&& (wake_pin == wakecfg_ff[pmsc_pkg::WCFG_PIN_POL_BIT])
		&& (pin_prev_ff != wakecfg_ff[pmsc_pkg::WCFG_PIN_POL_BIT]);
	// Greater-or-equal so that a large increment cannot step over the compare value.
	assign tmr_hit = wakecfg_ff[pmsc_pkg::WCFG_TMR_EN_BIT] && (cnt_ff >= cmp_ff);
	assign wake_go = state_ff == pmsc_pkg::ST_ASLEEP && (pend_pin_ff || pend_tmr_ff);
	assign pg_fail = (state_ff == pmsc_pkg::ST_TO_SLEEP || state_ff == pmsc_pkg::ST_TO_WAKE)
		&& (supply_good & supply_enable) != supply_enable;

	// Previous pin level for edge detection.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pin_prev_ff <= 1'b0;
		end else begin
			pin_prev_ff <= wake_pin;
		end
	end

	// Pending wakes are held through sleep entry and cleared when the wake begins.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pend_pin_ff <= 1'b0;
			pend_tmr_ff <= 1'b0;
		end else if (state_ff == pmsc_pkg::ST_TO_SLEEP || state_ff == pmsc_pkg::ST_ASLEEP) begin
			pend_pin_ff <= (pend_pin_ff || pin_edge) && !wake_go;
			pend_tmr_ff <= (pend_tmr_ff || tmr_hit) && !wake_go;
		end else begin
			pend_pin_ff <= 1'b0;
			pend_tmr_ff <= 1'b0;
		end
	end

	// ************************************************************
	// Power state machine.
	// ************************************************************
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			pmsc_pkg::ST_AWAKE: begin
				if (sleep_req) begin
					nxt_state = pmsc_pkg::ST_TO_SLEEP;
				end
			end
			pmsc_pkg::ST_TO_SLEEP: begin
				if (pg_fail) begin
					nxt_state = pmsc_pkg::ST_FAULT;
				end else if (tcnt_ff == TRANS_LAST) begin
					nxt_state = pmsc_pkg::ST_ASLEEP;
				end
			end
			pmsc_pkg::ST_ASLEEP: begin
				if (wake_go) begin
					nxt_state = pmsc_pkg::ST_TO_WAKE;
				end
			end
			pmsc_pkg::ST_TO_WAKE: begin
				if (pg_fail) begin
					nxt_state = pmsc_pkg::ST_FAULT;
				end else if (tcnt_ff == TRANS_LAST) begin
					nxt_state = pmsc_pkg::ST_AWAKE;
				end
			end
			pmsc_pkg::ST_FAULT: begin
				nxt_state = pmsc_pkg::ST_AWAKE; // Reset pulse lasts one cycle, then run.
			end
			default: begin
				nxt_state = pmsc_pkg::ST_AWAKE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= pmsc_pkg::ST_AWAKE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Transition dwell counter restarts at every state change.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tcnt_ff <= 3'h0;
		end else if (nxt_state != state_ff) begin
			tcnt_ff <= 3'h0;
		end else if (tcnt_ff != TRANS_LAST) begin
			tcnt_ff <= tcnt_ff + 3'h1;
		end
	end

	// System reset is registered so it is a clean one-cycle pulse.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sys_rst_ff <= 1'b0;
		end else begin
			sys_rst_ff <= pg_fail;
		end
	end

	// ************************************************************
	// Real-time counter.
	// ************************************************************
	assign slow_tick = slow_ff == SLOW_LAST;

	// Divider that models the slow oscillator tick from the main clock.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slow_ff <= 16'h0000;
		end else if (slow_tick) begin
			slow_ff <= 16'h0000;
		end else begin
			slow_ff <= slow_ff + 16'h0001;
		end
	end

	// Software writes take priority over counting so a load is never lost.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= 64'h0;
		end else if (wr_en && paddr == pmsc_pkg::OFF_CNT_LO) begin
			cnt_ff[31:0] <= pwdata;
		end else if (wr_en && paddr == pmsc_pkg::OFF_CNT_HI) begin
			cnt_ff[63:32] <= pwdata;
		end else if (state_ff == pmsc_pkg::ST_ASLEEP && wakecfg_ff[pmsc_pkg::WCFG_SLOW_BIT]) begin
			if (slow_tick) begin
				cnt_ff <= cnt_ff + {32'h0, incr_ff};
			end
		end else begin
			cnt_ff <= cnt_ff + 64'h1;
		end
	end

	// ************************************************************
	// Configuration registers.
	// ************************************************************
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sleepcfg_ff <= pmsc_pkg::SLEEPCFG_RST;
			wakecfg_ff <= pmsc_pkg::WAKECFG_RST;
			cmp_ff <= pmsc_pkg::CMP_RST;
			incr_ff <= pmsc_pkg::INCR_RST;
			mask_ff <= pmsc_pkg::IRQ_MASK_RST;
		end else if (wr_en) begin
			unique case (paddr)
				pmsc_pkg::OFF_SLEEPCFG: sleepcfg_ff <= pwdata[5:0];
				pmsc_pkg::OFF_WAKECFG: wakecfg_ff <= pwdata[3:0];
				pmsc_pkg::OFF_CMP_LO: cmp_ff[31:0] <= pwdata;
				pmsc_pkg::OFF_CMP_HI: cmp_ff[63:32] <= pwdata;
				pmsc_pkg::OFF_INCR: incr_ff <= pwdata;
				pmsc_pkg::OFF_IRQ_MASK: mask_ff <= pwdata[2:0];
				default: ;
			endcase
		end
	end

	// Sticky status; a new event in the clearing cycle wins over the clear.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			stat_ff <= 3'h0;
		end else begin
			stat_ff <= (stat_ff & ~((wr_en && paddr == pmsc_pkg::OFF_IRQ_STAT) ? pwdata[2:0] : 3'h0))
				| {pg_fail, wake_go && pend_tmr_ff, wake_go && pend_pin_ff};
		end
	end

	// Deep sleep memory; it has no reset so contents survive sleep.
	always_ff @(posedge clk) begin
		if (wr_en && in_mem) begin
			mem[mem_idx] <= pwdata[7:0];
		end
	end

	// Read data is registered in the setup cycle so it is valid in the access phase.
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= 32'h0;
		end else if (rd_en) begin
			if (in_mem) begin
				prdata <= {24'h0, mem[mem_idx]};
			end else begin
				unique case (paddr)
					pmsc_pkg::OFF_SLEEPCFG: prdata <= {26'h0, sleepcfg_ff};
					pmsc_pkg::OFF_WAKECFG: prdata <= {28'h0, wakecfg_ff};
					pmsc_pkg::OFF_STATE: prdata <= {29'h0, state_ff};
					pmsc_pkg::OFF_CNT_LO: prdata <= cnt_ff[31:0];
					pmsc_pkg::OFF_CNT_HI: prdata <= cnt_ff[63:32];
					pmsc_pkg::OFF_CMP_LO: prdata <= cmp_ff[31:0];
					pmsc_pkg::OFF_CMP_HI: prdata <= cmp_ff[63:32];
					pmsc_pkg::OFF_INCR: prdata <= incr_ff;
					pmsc_pkg::OFF_IRQ_STAT: prdata <= {29'h0, stat_ff};
					pmsc_pkg::OFF_IRQ_MASK: prdata <= {29'h0, mask_ff};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end

	// ************************************************************
	// Power outputs; sleep settings apply outside the running state.
	// ************************************************************
	always_comb begin
		if (state_ff == pmsc_pkg::ST_AWAKE) begin
			supply_enable = '1;
			pulse_frequency_supply_mode = '0;
			clock_mask = 1'b0;
			node_reset = 1'b0;
			node_power_enable = 1'b1;
		end else begin
			supply_enable = sleepcfg_ff[pmsc_pkg::CFG_SUP_EN_LSB +: N_SUP];
			pulse_frequency_supply_mode = sleepcfg_ff[pmsc_pkg::CFG_PFM_LSB +: N_SUP];
			clock_mask = sleepcfg_ff[pmsc_pkg::CFG_CLK_MASK_BIT];
			node_reset = sleepcfg_ff[pmsc_pkg::CFG_RESET_BIT];
			node_power_enable = state_ff != pmsc_pkg::ST_ASLEEP;
		end
	end

	assign watchdog_enable = state_ff == pmsc_pkg::ST_AWAKE;
	assign system_reset = sys_rst_ff;
	assign irq = |(stat_ff & mask_ff);

endmodule : pmsc_ctrl

`default_nettype wire

//--- shared/pmsc_pkg.sv
// Package of constants and types for the power mode sleep controller.
package pmsc_pkg;

	// ************************************************************
	// Register offsets (byte addresses on the APB).
	// ************************************************************
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_SLEEPCFG = 8'h04;
	localparam logic [7:0] OFF_WAKECFG = 8'h08;
	localparam logic [7:0] OFF_STATE = 8'h0c;
	localparam logic [7:0] OFF_CNT_LO = 8'h10;
	localparam logic [7:0] OFF_CNT_HI = 8'h14;
	localparam logic [7:0] OFF_CMP_LO = 8'h18;
	localparam logic [7:0] OFF_CMP_HI = 8'h1c;
	localparam logic [7:0] OFF_INCR = 8'h20;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
	localparam logic [7:0] OFF_MEM_BASE = 8'h80;

	// ************************************************************
	// Field positions.
	// ************************************************************
	localparam int CTRL_SLEEP_BIT = 0;
	localparam int CFG_SUP_EN_LSB = 0;
	localparam int CFG_PFM_LSB = 2;
	localparam int CFG_CLK_MASK_BIT = 4;
	localparam int CFG_RESET_BIT = 5;
	localparam int WCFG_PIN_EN_BIT = 0;
	localparam int WCFG_PIN_POL_BIT = 1;
	localparam int WCFG_TMR_EN_BIT = 2;
	localparam int WCFG_SLOW_BIT = 3;
	localparam int IRQ_WAKE_PIN_BIT = 0;
	localparam int IRQ_WAKE_TMR_BIT = 1;
	localparam int IRQ_PG_FAIL_BIT = 2;

	// ************************************************************
	// Reset values and timing counts.
	// ************************************************************
	localparam logic [5:0] SLEEPCFG_RST = 6'h03;
	localparam logic [3:0] WAKECFG_RST = 4'h0;
	localparam logic [31:0] INCR_RST = 32'h00000001;
	localparam logic [63:0] CMP_RST = 64'hffffffffffffffff;
	localparam logic [2:0] IRQ_MASK_RST = 3'h0;
	localparam int SLOW_HZ = 31250;
	localparam int TRANS_CYCLES = 4;
	localparam int MEM_BYTES = 128;

	// ************************************************************
	// Power states.
	// ************************************************************
	typedef enum logic [2:0] {
		ST_AWAKE = 3'b000,
		ST_TO_SLEEP = 3'b001,
		ST_ASLEEP = 3'b010,
		ST_TO_WAKE = 3'b011,
		ST_FAULT = 3'b100
	} pmsc_state_type;

endpackage : pmsc_pkg

//--- verif/pmsc_wake_model.sv
// Far-side model: wake pin and supply power-good levels.
`timescale 1ns/10ps
`default_nettype none
// ********
// Pin and supply drive.
// ********
module pmsc_wake_model (
	input wire logic clk,
	input wire logic pin_cmd,
	input wire logic [1:0] good_cmd,
	output logic wake_pin,
	output logic [1:0] supply_good
);
	// Levels settle one edge after the bench asks, like a real pin.
	always_ff @(posedge clk) begin
		wake_pin <= pin_cmd;
		supply_good <= good_cmd;
	end
endmodule : pmsc_wake_model
`default_nettype wire

//--- verif/pmsc_ctrl_monitor.sv
// Checker of the power state outputs of the controller.
`timescale 1ns/10ps
`default_nettype none
// ********
// Checker.
// ********
module pmsc_ctrl_monitor #(
	parameter int N_SUP = 2
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [N_SUP-1:0] supply_good,
	input wire logic [N_SUP-1:0] supply_enable,
	input wire logic [N_SUP-1:0] pulse_frequency_supply_mode,
	input wire logic node_power_enable,
	input wire logic clock_mask,
	input wire logic node_reset,
	input wire logic system_reset,
	input wire logic watchdog_enable
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// A transition state: neither running nor powered down.
	sequence s_trans;
		node_power_enable && !watchdog_enable;
	endsequence
	chk_node_wdog: assert property (!node_power_enable |-> !watchdog_enable)
		else $error("watchdog on while asleep");
	chk_run_exit: assert property ($fell(watchdog_enable) |-> s_trans ##1 s_trans)
		else $error("run left without transition");
	chk_sleep_exit: assert property ($rose(node_power_enable) |-> s_trans ##1 s_trans)
		else $error("sleep left without transition");
	chk_sleep_write: assert property (psel && penable && pwrite &&
		paddr == pmsc_pkg::OFF_CTRL && pwdata[0] && watchdog_enable |=> !watchdog_enable)
		else $error("sleep write ignored");
	chk_run_outputs: assert property (watchdog_enable |-> (&supply_enable) &&
		pulse_frequency_supply_mode == '0 && !clock_mask && !node_reset)
		else $error("sleep settings applied while running");
	chk_pg_reset: assert property ($fell(&supply_good) && !watchdog_enable &&
		node_power_enable |-> ##[1:2] system_reset)
		else $error("power-good loss not reset");
	chk_rst_pulse: assert property (system_reset |=> !system_reset)
		else $error("reset pulse too long");
	chk_rst_return: assert property (system_reset |-> ##[1:2] watchdog_enable)
		else $error("no return to run after reset");
endmodule : pmsc_ctrl_monitor
bind pmsc_ctrl pmsc_ctrl_monitor #(.N_SUP(N_SUP)) u_mon (.clk, .nrst, .psel, .penable,
	.pwrite, .paddr, .pwdata, .supply_good, .supply_enable, .pulse_frequency_supply_mode,
	.node_power_enable, .clock_mask, .node_reset, .system_reset, .watchdog_enable);
`default_nettype wire

//--- verif/power_mode_sleep_controller_tb_top.sv
// Self-checking bench for the power mode controller.
`timescale 1ns/10ps
`default_nettype none
// ********
// Bench top.
// ********
module power_mode_sleep_controller_tb_top;
	logic clk = 1'b0;
	logic nrst, psel, penable, pwrite, pready, pslverr, wake_pin, pin_cmd;
	logic node_power_enable, clock_mask, node_reset, system_reset, watchdog_enable, irq;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, q0;
	logic [1:0] supply_good, good_cmd, supply_enable, pulse_frequency_supply_mode;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	int n;
	pmsc_ctrl DUT (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .wake_pin, .supply_good, .supply_enable, .pulse_frequency_supply_mode,
		.node_power_enable, .clock_mask, .node_reset, .system_reset, .watchdog_enable, .irq);
	pmsc_wake_model u_far (.clk, .pin_cmd, .good_cmd, .wake_pin, .supply_good);
	// Clock, and a ceiling well above the slow timer wake so a hang ends.
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			conclude();
		end
	end
	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	task automatic chk(input string s, input logic [31:0] v, input logic [31:0] e);
		check_count++;
		if (v !== e) begin
			err_total++;
			$display("BAD %s exp %h seen %h", s, e, v);
		end
	endtask : chk
	// One APB transfer; request held until pready is seen high.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : bus
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string s);
		bus(1'b0, a, 32'h0, q);
		chk(s, q, e);
		chk("resp", {pready, pslverr}, 32'h2);
	endtask : rc
	// Bounded wait, sampled just after the edge so updates have landed.
	task automatic wait_sig(ref logic x, input logic v, input string s);
		for (int i = 0; i < 20000 && x !== v; i++) begin
			@(posedge clk);
			#1;
		end
		chk(s, x, v);
	endtask : wait_sig
	task automatic t_reset;
		rc(pmsc_pkg::OFF_SLEEPCFG, 32'h3, "sleepcfg");
		rc(pmsc_pkg::OFF_INCR, 32'h1, "incr");
		rc(pmsc_pkg::OFF_CMP_LO, 32'hffffffff, "cmp");
		rc(8'h40, 32'h0, "unmapped");
		chk("wdog", watchdog_enable, 32'h1);
		bus(1'b0, pmsc_pkg::OFF_CNT_LO, 32'h0, q0);
		bus(1'b0, pmsc_pkg::OFF_CNT_LO, 32'h0, q);
		chk("cnt step", q - q0, 32'h3);
		$display("done reset");
	endtask : t_reset
	task automatic t_pin;
		bus(1'b1, pmsc_pkg::OFF_SLEEPCFG, 32'h3e, q);
		bus(1'b1, pmsc_pkg::OFF_WAKECFG, 32'h3, q);
		bus(1'b1, pmsc_pkg::OFF_MEM_BASE, 32'ha5, q);
		bus(1'b1, pmsc_pkg::OFF_CTRL, 32'h1, q);
		rc(pmsc_pkg::OFF_STATE, 32'h1, "entry");
		wait_sig(node_power_enable, 1'b0, "asleep");
		chk("sup", {supply_enable, pulse_frequency_supply_mode}, 32'hb);
		chk("clk rst", {clock_mask, node_reset, watchdog_enable}, 32'h6);
		pin_cmd <= 1'b1;
		wait_sig(watchdog_enable, 1'b1, "pin wake");
		rc(pmsc_pkg::OFF_MEM_BASE, 32'ha5, "mem");
		rc(pmsc_pkg::OFF_IRQ_STAT, 32'h1, "stat pin");
		bus(1'b1, pmsc_pkg::OFF_IRQ_MASK, 32'h0, q);
		#1 chk("irq off", irq, 32'h0);
		bus(1'b1, pmsc_pkg::OFF_IRQ_MASK, 32'h7, q);
		#1 chk("irq on", irq, 32'h1);
		bus(1'b1, pmsc_pkg::OFF_IRQ_STAT, 32'h7, q);
		#1 chk("irq clr", irq, 32'h0);
		pin_cmd <= 1'b0;
		$display("done pin");
	endtask : t_pin
	// A pin edge while running is dropped, a falling wake works, and an edge in sleep entry is held.
	task automatic t_held;
		@(posedge clk);
		pin_cmd <= 1'b1;
		repeat (3) @(posedge clk);
		pin_cmd <= 1'b0;
		rc(pmsc_pkg::OFF_STATE, 32'h0, "awake pin");
		bus(1'b1, pmsc_pkg::OFF_CTRL, 32'h1, q);
		wait_sig(node_power_enable, 1'b0, "quiet sleep");
		repeat (20) @(posedge clk);
		rc(pmsc_pkg::OFF_STATE, 32'h2, "no stale wake");
		bus(1'b1, pmsc_pkg::OFF_WAKECFG, 32'h1, q);
		pin_cmd <= 1'b1;
		repeat (20) @(posedge clk);
		rc(pmsc_pkg::OFF_STATE, 32'h2, "rise ignored");
		pin_cmd <= 1'b0;
		wait_sig(watchdog_enable, 1'b1, "fall wake");
		rc(pmsc_pkg::OFF_IRQ_STAT, 32'h1, "stat fall");
		bus(1'b1, pmsc_pkg::OFF_IRQ_STAT, 32'h7, q);
		bus(1'b1, pmsc_pkg::OFF_WAKECFG, 32'h3, q);
		bus(1'b1, pmsc_pkg::OFF_CTRL, 32'h1, q);
		pin_cmd <= 1'b1;
		wait_sig(node_power_enable, 1'b0, "held sleep");
		wait_sig(watchdog_enable, 1'b1, "held wake");
		pin_cmd <= 1'b0;
		rc(pmsc_pkg::OFF_IRQ_STAT, 32'h1, "stat held");
		bus(1'b1, pmsc_pkg::OFF_IRQ_STAT, 32'h7, q);
		$display("done held");
	endtask : t_held
	// An increment of 0x40 never lands on 0x90, so only a compare by size can wake.
	task automatic t_timer;
		bus(1'b1, pmsc_pkg::OFF_WAKECFG, 32'hc, q);
		bus(1'b1, pmsc_pkg::OFF_INCR, 32'h40, q);
		bus(1'b1, pmsc_pkg::OFF_CNT_LO, 32'h0, q);
		bus(1'b1, pmsc_pkg::OFF_CMP_HI, 32'h0, q);
		bus(1'b1, pmsc_pkg::OFF_CMP_LO, 32'h90, q);
		bus(1'b1, pmsc_pkg::OFF_CTRL, 32'h1, q);
		wait_sig(node_power_enable, 1'b0, "tmr sleep");
		for (n = 0; n < 20000 && watchdog_enable !== 1'b1; n++) begin
			@(posedge clk);
		end
		chk("slow span", n > 3200 && n < 20000, 32'h1);
		rc(pmsc_pkg::OFF_IRQ_STAT, 32'h2, "stat tmr");
		bus(1'b1, pmsc_pkg::OFF_IRQ_STAT, 32'h7, q);
		$display("done timer");
	endtask : t_timer
	task automatic t_pg;
		bus(1'b1, pmsc_pkg::OFF_CTRL, 32'h1, q);
		good_cmd <= 2'b01;
		wait_sig(system_reset, 1'b1, "sys rst");
		good_cmd <= 2'b11;
		wait_sig(watchdog_enable, 1'b1, "pg back");
		rc(pmsc_pkg::OFF_IRQ_STAT, 32'h4, "stat pg");
		$display("done pg");
	endtask : t_pg
	// Reset held for eight cycles, then the scenarios in turn.
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pin_cmd = 1'b0;
		good_cmd = 2'b11;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_pin();
		t_held();
		t_timer();
		t_pg();
		conclude();
	end
endmodule : power_mode_sleep_controller_tb_top
`default_nettype wire
